// File: verilog/ssd_pkg.sv
`default_nettype none
package ssd_pkg;
    // record field positions
    localparam int SECURE_BIT      = 509;
    localparam int PA_MSB          = 479;
    localparam int PA_LSB          = 448;
    localparam int SPEED_MSB       = 447;
    localparam int SPEED_LSB       = 440;
    localparam int MOVE_MSB        = 439;
    localparam int MOVE_LSB        = 432;
    localparam int AU_MSB          = 431;
    localparam int AU_LSB          = 428;
    localparam int ERASE_CNT_MSB   = 423;
    localparam int ERASE_CNT_LSB   = 408;
    localparam int ERASE_TIME_MSB  = 407;
    localparam int ERASE_TIME_LSB  = 402;
    localparam int ERASE_OFS_MSB   = 401;
    localparam int ERASE_OFS_LSB   = 400;
    localparam int REC_W           = 512;
    // code limits
    localparam logic [7:0] SPEED_MAX_CODE  = 8'h03;
    localparam logic [7:0] MOVE_UNDEF      = 8'h00;
    localparam logic [7:0] MOVE_UNLIMITED  = 8'hff;
    localparam logic [3:0] AU_UNDEF        = 4'h0;
    localparam logic [3:0] AU_MAX_CODE     = 4'h9;
    localparam logic [15:0] ERASE_CNT_NONE = 16'h0000;
    localparam logic [5:0] ERASE_TIME_NONE = 6'h00;
    // allocation unit length in KB at code 1
    localparam logic [12:0] AU_BASE_KB     = 13'h0010;
    localparam logic [1:0]  GRADE_STEP_SH  = 2'h1;
endpackage : ssd_pkg
`default_nettype wire

// File: verilog/ssd_mul.sv
`timescale 1ns/1ps
`default_nettype none
// registered product of protected-area size and unit
module ssd_mul
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        en_i,
    input  wire logic [31:0] a_i,
    input  wire logic [31:0] b_i,
    output logic      [63:0] p_o
);
    typedef struct packed
    {
        logic [63:0] p;
    } ssd_mul_st_t;

    ssd_mul_st_t st_q;
    ssd_mul_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (en_i)
        begin
            st_d.p = a_i * b_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign p_o = st_q.p;
endmodule : ssd_mul
`default_nettype wire

// File: verilog/ssd_status_decoder.sv
// Functional notes
// - bit 509 set means card runs in secure mode, clear means not.
// - standard capacity: protected area is size times multiplier times block length.
// - high capacity: protected area is the size field itself, in bytes.
// - speed codes 0..3 map to grades 0,2,4,6; codes 04h..FFh are reserved.
// - move code in 1 MB/s steps; 00h undefined, FFh unlimited.
// - allocation unit is 16KB shifted by code minus one; 0 undefined, Ah..Fh reserved.
// - erase count is units per timeout; 0000h means timeout not supported.
// - erase timeout code is 1..63 seconds; 00 means not supported.
// - erase offset 0..3 s, meaningless when erase count and timeout are zero.
// - speed code sits at record bits 447:440.
// - allocation unit code sits at record bits 431:428.
// - protected-area size sits at record bits 479:448.
// - erase count 423:408, timeout 407:402, offset 401:400.
`timescale 1ns/1ps
`default_nettype none
module ssd_status_decoder
(
    input  wire logic          REF_CLK_I,
    input  wire logic          SYS_RST_I,
    input  wire logic          REC_VALID_I,
    input  wire logic [511:0]  REC_DATA_I,
    input  wire logic          HIGH_CAP_I,
    input  wire logic [31:0]   CAPACITY_CAPACITY_MULTIPLIER_I,
    input  wire logic [31:0]   BLOCK_LENGTH_I,
    output logic               VALID_O,
    output logic               SECURE_OP_FLAG_O,
    output logic [31:0]        PROTECTED_AREA_SIZE_O,
    output logic [63:0]        PROTECTED_AREA_BYTES_O,
    output logic [7:0]         SPEED_CODE_O,
    output logic [3:0]         SPEED_GRADE_O,
    output logic               SPEED_RESERVED_O,
    output logic [7:0]         MOVE_RATE_MBPS_O,
    output logic               MOVE_UNDEF_O,
    output logic               MOVE_UNLIMITED_O,
    output logic [3:0]         ALLOC_UNIT_LENGTH_CODE_O,
    output logic [12:0]        ALLOC_UNIT_KB_O,
    output logic               ALLOC_UNIT_UNDEF_O,
    output logic               ALLOC_UNIT_RESERVED_O,
    output logic [15:0]        ERASE_AU_COUNT_O,
    output logic               ERASE_COUNT_UNSUPP_O,
    output logic [5:0]         ERASE_TIME_VALUE_O,
    output logic               ERASE_TIME_UNSUPP_O,
    output logic [1:0]         ERASE_TIME_OFFSET_O,
    output logic               ERASE_OFFSET_VALID_O
);
    typedef struct packed
    {
        logic        valid;
        logic        secure;
        logic [31:0] pa_size;
        logic [7:0]  speed;
        logic [3:0]  grade;
        logic        speed_rsv;
        logic [7:0]  move;
        logic        move_undef;
        logic        move_unl;
        logic [3:0]  au_code;
        logic [12:0] au_kb;
        logic        au_undef;
        logic        au_rsv;
        logic [15:0] erase_cnt;
        logic        erase_cnt_na;
        logic [5:0]  erase_time;
        logic        erase_time_na;
        logic [1:0]  erase_ofs;
        logic        erase_ofs_ok;
    } ssd_dec_st_t;

    ssd_dec_st_t st_q;
    ssd_dec_st_t st_d;
    logic [31:0] unit_w;
    logic [31:0] mul_b_w;
    logic [63:0] pa_prod_w;
    logic        secure_w;
    logic [31:0] pa_w;
    logic [7:0]  speed_w;
    logic [7:0]  move_w;
    logic [3:0]  au_w;
    logic [15:0] cnt_w;
    logic [5:0]  time_w;
    logic [1:0]  ofs_w;

    // =========================================================
    // field extraction
    // =========================================================
    // secure bit
    assign secure_w = REC_DATA_I[ssd_pkg::SECURE_BIT];

    assign pa_w = REC_DATA_I[ssd_pkg::PA_MSB:ssd_pkg::PA_LSB];

    assign speed_w = REC_DATA_I[ssd_pkg::SPEED_MSB:ssd_pkg::SPEED_LSB];

    assign move_w  = REC_DATA_I[ssd_pkg::MOVE_MSB:ssd_pkg::MOVE_LSB];

    assign au_w    = REC_DATA_I[ssd_pkg::AU_MSB:ssd_pkg::AU_LSB];

    assign cnt_w   = REC_DATA_I[ssd_pkg::ERASE_CNT_MSB:ssd_pkg::ERASE_CNT_LSB];
    assign time_w  = REC_DATA_I[ssd_pkg::ERASE_TIME_MSB:ssd_pkg::ERASE_TIME_LSB];
    assign ofs_w   = REC_DATA_I[ssd_pkg::ERASE_OFS_MSB:ssd_pkg::ERASE_OFS_LSB];

    // =========================================================
    // protected area
    // =========================================================
    // unit is multiplier times block length
    assign unit_w = 32'(CAPACITY_CAPACITY_MULTIPLIER_I * BLOCK_LENGTH_I);

    // high capacity scales by one, field counts bytes
    assign mul_b_w = HIGH_CAP_I ? 32'h1 : unit_w;

    ssd_mul u_mul
    (
        .clk_i (REF_CLK_I),
        .rst_i (SYS_RST_I),
        .en_i  (REC_VALID_I),
        .a_i   (pa_w),
        .b_i   (mul_b_w),
        .p_o   (pa_prod_w)
    );

    assign PROTECTED_AREA_BYTES_O = pa_prod_w;

    // =========================================================
    // decode
    // =========================================================
    always_comb
    begin
        st_d = st_q;

        if (REC_VALID_I)
        begin
            st_d.valid    = 1'b1;

            st_d.secure   = secure_w;

            st_d.pa_size  = pa_w;

            st_d.speed     = speed_w;
            st_d.speed_rsv = speed_w > ssd_pkg::SPEED_MAX_CODE;
            st_d.grade     = st_d.speed_rsv ? 4'h0 : 4'({2'h0, speed_w[1:0]} << ssd_pkg::GRADE_STEP_SH);

            // move rate, all ones is unlimited
            st_d.move       = move_w;
            st_d.move_undef = move_w == ssd_pkg::MOVE_UNDEF;
            st_d.move_unl   = move_w == ssd_pkg::MOVE_UNLIMITED;

            st_d.au_code  = au_w;
            st_d.au_undef = au_w == ssd_pkg::AU_UNDEF;
            st_d.au_rsv   = au_w > ssd_pkg::AU_MAX_CODE;
            st_d.au_kb    = (st_d.au_undef || st_d.au_rsv) ? 13'h0 :
                            13'(ssd_pkg::AU_BASE_KB << (au_w - 4'h1));

            st_d.erase_cnt    = cnt_w;
            st_d.erase_cnt_na = cnt_w == ssd_pkg::ERASE_CNT_NONE;

            st_d.erase_time    = time_w;
            st_d.erase_time_na = time_w == ssd_pkg::ERASE_TIME_NONE;

            st_d.erase_ofs    = ofs_w;
            st_d.erase_ofs_ok = !(st_d.erase_cnt_na && st_d.erase_time_na);
        end
    end

    // =========================================================
    // state register
    // =========================================================
    // synchronous clear
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    assign VALID_O                  = st_q.valid;
    assign SECURE_OP_FLAG_O         = st_q.secure;
    assign PROTECTED_AREA_SIZE_O    = st_q.pa_size;
    assign SPEED_CODE_O             = st_q.speed;
    assign SPEED_GRADE_O            = st_q.grade;
    assign SPEED_RESERVED_O         = st_q.speed_rsv;
    assign MOVE_RATE_MBPS_O         = st_q.move;
    assign MOVE_UNDEF_O             = st_q.move_undef;
    assign MOVE_UNLIMITED_O         = st_q.move_unl;
    assign ALLOC_UNIT_LENGTH_CODE_O = st_q.au_code;
    assign ALLOC_UNIT_KB_O          = st_q.au_kb;
    assign ALLOC_UNIT_UNDEF_O       = st_q.au_undef;
    assign ALLOC_UNIT_RESERVED_O    = st_q.au_rsv;
    assign ERASE_AU_COUNT_O         = st_q.erase_cnt;
    assign ERASE_COUNT_UNSUPP_O     = st_q.erase_cnt_na;
    assign ERASE_TIME_VALUE_O       = st_q.erase_time;
    assign ERASE_TIME_UNSUPP_O      = st_q.erase_time_na;
    assign ERASE_TIME_OFFSET_O      = st_q.erase_ofs;
    assign ERASE_OFFSET_VALID_O     = st_q.erase_ofs_ok;
endmodule : ssd_status_decoder
`default_nettype wire

// File: tb/ssd_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// decoder port checks
module ssd_properties
(
    input wire logic         REF_CLK_I,
    input wire logic         SYS_RST_I,
    input wire logic         REC_VALID_I,
    input wire logic [511:0] REC_DATA_I,
    input wire logic         HIGH_CAP_I,
    input wire logic         VALID_O,
    input wire logic         SECURE_OP_FLAG_O,
    input wire logic [31:0]  PROTECTED_AREA_SIZE_O,
    input wire logic [63:0]  PROTECTED_AREA_BYTES_O,
    input wire logic [7:0]   SPEED_CODE_O,
    input wire logic [3:0]   SPEED_GRADE_O,
    input wire logic         SPEED_RESERVED_O,
    input wire logic [7:0]   MOVE_RATE_MBPS_O,
    input wire logic         MOVE_UNDEF_O,
    input wire logic         MOVE_UNLIMITED_O,
    input wire logic [3:0]   ALLOC_UNIT_LENGTH_CODE_O,
    input wire logic [15:0]  ERASE_AU_COUNT_O,
    input wire logic [5:0]   ERASE_TIME_VALUE_O,
    input wire logic [1:0]   ERASE_TIME_OFFSET_O,
    input wire logic         ERASE_OFFSET_VALID_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_take; REC_VALID_I; endsequence
    property p_sec; s_take |=> SECURE_OP_FLAG_O == $past(REC_DATA_I[509]); endproperty
    a_sec: assert property (p_sec) else $error("secure flag");
    property p_fld; s_take |=> {SPEED_CODE_O, MOVE_RATE_MBPS_O, ALLOC_UNIT_LENGTH_CODE_O} == $past(REC_DATA_I[447:428]);
    endproperty
    a_fld: assert property (p_fld) else $error("code fields");
    property p_pas; s_take |=> PROTECTED_AREA_SIZE_O == $past(REC_DATA_I[479:448]); endproperty
    a_pas: assert property (p_pas) else $error("area size");
    property p_ers; s_take |=> {ERASE_AU_COUNT_O, ERASE_TIME_VALUE_O, ERASE_TIME_OFFSET_O} == $past(REC_DATA_I[423:400]);
    endproperty
    a_ers: assert property (p_ers) else $error("erase fields");
    property p_pa; REC_VALID_I && HIGH_CAP_I |=> PROTECTED_AREA_BYTES_O == {32'h0, PROTECTED_AREA_SIZE_O}; endproperty
    a_pa: assert property (p_pa) else $error("area bytes");
    property p_spd; VALID_O |-> SPEED_RESERVED_O == (SPEED_CODE_O > 8'h03)
        && SPEED_GRADE_O == (SPEED_RESERVED_O ? 4'h0 : {SPEED_CODE_O[2:0], 1'b0}); endproperty
    a_spd: assert property (p_spd) else $error("speed grade");
    property p_mov; VALID_O |-> MOVE_UNDEF_O == (MOVE_RATE_MBPS_O == 8'h00)
        && MOVE_UNLIMITED_O == (MOVE_RATE_MBPS_O == 8'hff); endproperty
    a_mov: assert property (p_mov) else $error("move flags");
    property p_eok; VALID_O |-> ERASE_OFFSET_VALID_O == (ERASE_AU_COUNT_O != 16'h0 || ERASE_TIME_VALUE_O != 6'h0);
    endproperty
    a_eok: assert property (p_eok) else $error("offset valid");
    property p_hold; !REC_VALID_I |=> $stable(PROTECTED_AREA_SIZE_O) && $stable(ERASE_AU_COUNT_O) && $stable(VALID_O);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved");
endmodule : ssd_properties
bind ssd_status_decoder ssd_properties i_ssd_properties (.*);
`default_nettype wire

// File: tb/ssd_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// card filling the status record
module ssd_card_model
(
    input  wire logic [511:0] noise_i,
    input  wire logic [79:0]  field_i,
    input  wire logic         sec_i,
    input  wire logic         no_ru_i,
    input  wire logic         strict_i,
    input  wire logic [1:0]   cap_i,
    output logic      [511:0] rec_o
);
    always_comb
    begin
        rec_o = noise_i;
        rec_o[509] = sec_i;
        rec_o[479:400] = field_i;
        if (no_ru_i)
            rec_o[439:432] = 8'hff;
        if (strict_i && (field_i[31:28] > 4'h6 + cap_i || field_i[31:28] == 4'h0))
            rec_o[431:428] = 4'h6 + cap_i;
    end
endmodule : ssd_card_model
`default_nettype wire

// File: tb/sd_status_field_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// random records with corner codes
module sd_status_field_decoder_tb_top;
    logic REF_CLK_I = 1'b0, SYS_RST_I = 1'b1, REC_VALID_I = 1'b0, HIGH_CAP_I = 1'b0;
    logic [31:0] CAPACITY_CAPACITY_MULTIPLIER_I = 32'h1, BLOCK_LENGTH_I = 32'h1, st = 32'ha030, r1, r2, r3, em;
    logic [511:0] REC_DATA_I, noise = '0;
    logic [79:0] fld = '0, ef;
    logic [1:0] cap = 2'h0;
    logic sec = 1'b0, nru = 1'b0, strict = 1'b0, es, eh;
    int errors = 0, total_checks = 0;
    logic VALID_O, SECURE_OP_FLAG_O, SPEED_RESERVED_O, MOVE_UNDEF_O, MOVE_UNLIMITED_O, ALLOC_UNIT_UNDEF_O;
    logic ALLOC_UNIT_RESERVED_O, ERASE_COUNT_UNSUPP_O, ERASE_TIME_UNSUPP_O, ERASE_OFFSET_VALID_O;
    logic [31:0] PROTECTED_AREA_SIZE_O;
    logic [63:0] PROTECTED_AREA_BYTES_O;
    logic [7:0] SPEED_CODE_O, MOVE_RATE_MBPS_O;
    logic [3:0] SPEED_GRADE_O, ALLOC_UNIT_LENGTH_CODE_O;
    logic [12:0] ALLOC_UNIT_KB_O;
    logic [15:0] ERASE_AU_COUNT_O;
    logic [5:0] ERASE_TIME_VALUE_O;
    logic [1:0] ERASE_TIME_OFFSET_O;
    ssd_status_decoder i_ssd_status_decoder (.*);
    ssd_card_model i_ssd_card_model (.noise_i(noise), .field_i(fld), .sec_i(sec), .no_ru_i(nru),
        .strict_i(strict), .cap_i(cap), .rec_o(REC_DATA_I));
    always #2.5 REF_CLK_I = ~REF_CLK_I;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic check_all;
        logic [3:0] a;
        a = ef[31:28];
        chk("valid", VALID_O, 1'b1);
        chk("secure", SECURE_OP_FLAG_O, es);
        chk("pa", PROTECTED_AREA_SIZE_O, ef[79:48]);
        chk("bytes", PROTECTED_AREA_BYTES_O, eh ? {32'h0, ef[79:48]} : ef[79:48] * em);
        chk("speed", {SPEED_CODE_O, SPEED_GRADE_O, SPEED_RESERVED_O},
            {ef[47:40], ef[47:40] > 8'h03 ? 4'h0 : {ef[42:40], 1'b0}, ef[47:40] > 8'h03});
        chk("move", {MOVE_RATE_MBPS_O, MOVE_UNDEF_O, MOVE_UNLIMITED_O},
            {ef[39:32], ef[39:32] == 8'h00, ef[39:32] == 8'hff});
        chk("au", {ALLOC_UNIT_LENGTH_CODE_O, ALLOC_UNIT_KB_O, ALLOC_UNIT_UNDEF_O, ALLOC_UNIT_RESERVED_O},
            {a, (a == 4'h0 || a > 4'h9) ? 13'h0 : 13'h0010 << (a - 4'h1), a == 4'h0, a > 4'h9});
        chk("erase", {ERASE_AU_COUNT_O, ERASE_TIME_VALUE_O, ERASE_TIME_OFFSET_O, ERASE_COUNT_UNSUPP_O,
            ERASE_TIME_UNSUPP_O, ERASE_OFFSET_VALID_O}, {ef[23:0], ef[23:8] == 16'h0, ef[7:2] == 6'h0,
            ef[23:2] != 22'h0});
    endtask : check_all
    initial
    begin
        repeat (5000) @(posedge REF_CLK_I);
        errors++;
        report_and_stop();
    end
    initial
    begin
        for (int i = 0; i < 403; i++)
        begin
            @(negedge REF_CLK_I);
            if (i < 2 || i == 401)
                chk("reset", {VALID_O, SPEED_CODE_O, ERASE_AU_COUNT_O, PROTECTED_AREA_BYTES_O[31:0]}, 64'h0);
            else if (i > 2)
                check_all();
            SYS_RST_I = (i == 0) || (i == 400);
            if (i == 0)
                repeat (8) @(negedge REF_CLK_I);
            r1 = xs(st);
            r2 = xs(r1);
            r3 = xs(r2);
            st = r3;
            REC_VALID_I = (i > 1 && i < 22) || (i > 21 && r1[31:29] != 3'h0) || i == 400 || i == 401;
            strict = (i >= 22);
            cap = r1[1:0];
            HIGH_CAP_I = r1[2];
            sec = r1[3];
            nru = (i == 5) || (strict && r1[5:4] == 2'h3);
            CAPACITY_CAPACITY_MULTIPLIER_I = {24'h0, r1[13:6]} + 32'h1;
            BLOCK_LENGTH_I = 32'h200 << r1[15:14];
            noise = {16{r2 ^ r3}};
            fld[79:48] = r3;
            fld[47:40] = (i < 9) ? 8'(i - 2) : (i == 9) ? 8'hff : r1[23:16];
            fld[39:32] = (i == 2) ? 8'h00 : (i == 3) ? 8'hfe : (i == 4) ? 8'hff : r1[31:24];
            fld[31:24] = {strict ? 4'((r2[3:0] % (4'h6 + cap)) + 4'h1) : 4'(i - 2), r2[7:4]};
            fld[23:8] = (i == 2 || i == 4) ? 16'h0 : (i == 3) ? 16'hffff : r2[23:8];
            fld[7:0] = {(i == 2 || i == 6) ? 6'h0 : (i == 3) ? 6'h3f : r2[29:24], r2[31:30]};
            if (REC_VALID_I)
            begin
                ef = nru ? {fld[79:40], 8'hff, fld[31:0]} : fld;
                es = sec;
                eh = HIGH_CAP_I;
                em = CAPACITY_CAPACITY_MULTIPLIER_I * BLOCK_LENGTH_I;
            end
        end
        report_and_stop();
    end
endmodule : sd_status_field_decoder_tb_top
`default_nettype wire
